// ===== bstp_defs.vh
// Constants of the boundary-scan test port: codes, lengths, offsets.
// Included by bstp_top.v; holds definitions only.
`ifndef BSTP_DEFS_VH
`define BSTP_DEFS_VH

// Scan register lengths
`define BSTP_IR_LEN 4
`define BSTP_ID_LEN 32
`define BSTP_BND_LEN 266

// Instruction codes
`define BSTP_INS_EXTEST 4'h0
`define BSTP_INS_SAMPLE 4'h1
`define BSTP_INS_IDCODE 4'h2
`define BSTP_INS_CLAMP 4'h3
`define BSTP_INS_HIGHZ 4'h4
`define BSTP_INS_BYPASS 4'hf
`define BSTP_IR_CAPTURE 4'h1

// Identification field layout
`define BSTP_ID_REV_MSB 31
`define BSTP_ID_REV_LSB 28
`define BSTP_ID_DEV_MSB 27
`define BSTP_ID_DEV_LSB 12
`define BSTP_ID_VEN_MSB 11
`define BSTP_ID_VEN_LSB 1

// Test pin vector {trst_n, tdi, tms, tck}, idle values after reset
`define BSTP_PIN_TCK 0
`define BSTP_PIN_TMS 1
`define BSTP_PIN_TDI 2
`define BSTP_PIN_TRST 3
`define BSTP_PIN_IDLE 4'he

// AXI4-Lite register byte offsets
`define BSTP_REG_CTRL 4'h0
`define BSTP_REG_STATUS 4'h4
`define BSTP_REG_IDCODE 4'h8
`define BSTP_REG_NONE 4'hf
`define BSTP_CTRL_RST 32'h00000000
`define BSTP_CTRL_HOLD_BIT 0
`define BSTP_RESP_OKAY 2'h0
`define BSTP_RESP_SLVERR 2'h2

`endif

// ===== bstp_top.v
// Boundary-scan test access port: TAP controller, instruction, bypass,
// identification and 266-cell boundary registers, plus an AXI4-Lite
// window for control and status. The test pins come from outside mclk;
// the core capture vector is assumed to be on mclk already.
//
// How it works
// - Mode select is sampled at each test clock rise to step the controller.
// - Mode select, test input and test reset idle high when undriven.
// - Test input enters IR or selected data register on test clock rise.
// - Test output shifts IR or data register, changing on test clock fall.
// - Test output is high-impedance whenever no shift is in progress.
// - Test reset returns the whole scan structure to reset condition.
// - Test clock is independent; shifting never disturbs core logic.
// - Four-bit IR shifts in shift-IR and loads in update-IR; decoded code selects data register.
// - Bypass is one flip-flop between test input and output.
// - Boundary cell zero shifts out first; control cell one enables driver.
// - ID is 32 bits: revision, device, vendor, and bit zero one.
// - Code 0000 selects boundary chain and drives cells onto outputs.
// - Code 1111 selects bypass, pins stay in normal operation.
// - Code 0010 captures the ID value and selects the ID register.
// - Code 0100 selects bypass and forces all output drivers off.
// - Code 0011 selects bypass and drives held cells onto outputs.
// - Code 0001 selects boundary chain for capture and preload.
// - Boundary chain holds 266 cells numbered 0 to 265, fixed positions.
//
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "bstp_defs.vh"

module bstp_top #(
  parameter [3:0] ID_REVISION = 4'h1,   // Arbitrary value
  parameter [15:0] ID_DEVICE = 16'h5a3c, // Arbitrary value
  parameter [10:0] ID_VENDOR = 11'h0f1   // Arbitrary value
) (
  input wire mclk, // System clock, 100 MHz
  input wire rst, // Synchronous reset, active high
  input wire tck, // Test clock pin
  input wire tms, // Test mode select pin
  input wire tdi, // Test data input pin
  input wire trst_n, // Test reset pin, active low
  output reg tdo_q, // Test data output value
  output reg tdo_oe_q, // Test data output driver enable
  input wire [265:0] pin_capture, // Values seen at each cell position
  output reg [265:0] bnd_hold_q, // Held boundary cell values
  output reg [265:0] bnd_oe_q, // Driver enables from control cells
  output reg test_drive_q, // Outputs take held cell values
  output reg test_highz_q, // All device outputs forced off
  input wire [31:0] s_axi_awaddr, // AXI write address
  input wire s_axi_awvalid, // AXI write address valid
  output reg s_axi_awready, // AXI write address ready
  input wire [31:0] s_axi_wdata, // AXI write data
  input wire [3:0] s_axi_wstrb, // AXI write strobes
  input wire s_axi_wvalid, // AXI write data valid
  output reg s_axi_wready, // AXI write data ready
  output reg [1:0] s_axi_bresp, // AXI write response
  output reg s_axi_bvalid, // AXI write response valid
  input wire s_axi_bready, // AXI write response ready
  input wire [31:0] s_axi_araddr, // AXI read address
  input wire s_axi_arvalid, // AXI read address valid
  output reg s_axi_arready, // AXI read address ready
  output reg [31:0] s_axi_rdata, // AXI read data
  output reg [1:0] s_axi_rresp, // AXI read response
  output reg s_axi_rvalid, // AXI read data valid
  input wire s_axi_rready // AXI read data ready
);

  localparam [3:0] ST_TLR = 4'h0;
  localparam [3:0] ST_RTI = 4'h1;
  localparam [3:0] ST_SEL_DR = 4'h2;
  localparam [3:0] ST_CAP_DR = 4'h3;
  localparam [3:0] ST_SH_DR = 4'h4;
  localparam [3:0] ST_EX1_DR = 4'h5;
  localparam [3:0] ST_PAU_DR = 4'h6;
  localparam [3:0] ST_EX2_DR = 4'h7;
  localparam [3:0] ST_UPD_DR = 4'h8;
  localparam [3:0] ST_SEL_IR = 4'h9;
  localparam [3:0] ST_CAP_IR = 4'ha;
  localparam [3:0] ST_SH_IR = 4'hb;
  localparam [3:0] ST_EX1_IR = 4'hc;
  localparam [3:0] ST_PAU_IR = 4'hd;
  localparam [3:0] ST_EX2_IR = 4'he;
  localparam [3:0] ST_UPD_IR = 4'hf;

  localparam [1:0] SEL_BYP = 2'h0;
  localparam [1:0] SEL_ID = 2'h1;
  localparam [1:0] SEL_BND = 2'h2;

  // Standard TAP transition table
  function [3:0] tap_next;
    input [3:0] st;
    input m;
    begin
      case (st)
        ST_TLR: tap_next = m ? ST_TLR : ST_RTI;
        ST_RTI: tap_next = m ? ST_SEL_DR : ST_RTI;
        ST_SEL_DR: tap_next = m ? ST_SEL_IR : ST_CAP_DR;
        ST_CAP_DR: tap_next = m ? ST_EX1_DR : ST_SH_DR;
        ST_SH_DR: tap_next = m ? ST_EX1_DR : ST_SH_DR;
        ST_EX1_DR: tap_next = m ? ST_UPD_DR : ST_PAU_DR;
        ST_PAU_DR: tap_next = m ? ST_EX2_DR : ST_PAU_DR;
        ST_EX2_DR: tap_next = m ? ST_UPD_DR : ST_SH_DR;
        ST_UPD_DR: tap_next = m ? ST_SEL_DR : ST_RTI;
        ST_SEL_IR: tap_next = m ? ST_TLR : ST_CAP_IR;
        ST_CAP_IR: tap_next = m ? ST_EX1_IR : ST_SH_IR;
        ST_SH_IR: tap_next = m ? ST_EX1_IR : ST_SH_IR;
        ST_EX1_IR: tap_next = m ? ST_UPD_IR : ST_PAU_IR;
        ST_PAU_IR: tap_next = m ? ST_EX2_IR : ST_PAU_IR;
        ST_EX2_IR: tap_next = m ? ST_UPD_IR : ST_SH_IR;
        ST_UPD_IR: tap_next = m ? ST_SEL_DR : ST_RTI;
        default: tap_next = ST_TLR;
      endcase
    end
  endfunction

  // Instruction decode to data register selection
  function [1:0] dr_select;
    input [3:0] ins;
    begin
      case (ins)
        `BSTP_INS_EXTEST: dr_select = SEL_BND;
        `BSTP_INS_SAMPLE: dr_select = SEL_BND;
        `BSTP_INS_IDCODE: dr_select = SEL_ID;
        default: dr_select = SEL_BYP;
      endcase
    end
  endfunction

  // Three-state control cell positions in the chain
  function is_ctrl_cell;
    input integer i;
    begin
      is_ctrl_cell = ((i >= 28) && (i <= 73) && ((i - 28) % 3 == 0)) ||
        ((i % 2 == 1) && (((i >= 83) && (i <= 113)) || ((i >= 131) && (i <= 161)) ||
        ((i >= 179) && (i <= 209)) || ((i >= 227) && (i <= 257))));
    end
  endfunction

  // Pin synchroniser: three stages, change accepted when 2nd and 3rd agree
  reg [3:0] sync1_q;
  reg [3:0] sync2_q;
  reg [3:0] sync3_q;
  reg [3:0] pin_q;
  wire [3:0] agree;
  wire tck_rise;
  wire tck_fall;
  wire tap_rst;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_sync
      assign agree[gi] = (sync2_q[gi] == sync3_q[gi]);
    end
  endgenerate

  // idle high
  // Undriven mode, data and reset pins read as pulled high, so the filter resets them high and the test clock low
  always @(posedge mclk)
  begin
    if (rst)
    begin
      sync1_q <= `BSTP_PIN_IDLE;
      sync2_q <= `BSTP_PIN_IDLE;
      sync3_q <= `BSTP_PIN_IDLE;
      pin_q <= `BSTP_PIN_IDLE;
    end
    else
    begin
      sync1_q <= {trst_n, tdi, tms, tck};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      pin_q <= (agree & sync3_q) | (~agree & pin_q);
    end
  end

  // independent test clock
  // Test clock edges are found by sampling, never used as a clock
  assign tck_rise = agree[`BSTP_PIN_TCK] & sync3_q[`BSTP_PIN_TCK] & ~pin_q[`BSTP_PIN_TCK];
  assign tck_fall = agree[`BSTP_PIN_TCK] & ~sync3_q[`BSTP_PIN_TCK] & pin_q[`BSTP_PIN_TCK];

  reg [31:0] ctrl_q;
  assign tap_rst = rst | ~pin_q[`BSTP_PIN_TRST] | ctrl_q[`BSTP_CTRL_HOLD_BIT];

  reg [3:0] state_q;
  reg [3:0] ir_sr_q;
  reg [3:0] ir_q;
  reg byp_q;
  reg [31:0] id_sr_q;
  reg [265:0] bnd_sr_q;
  wire t_ms;
  wire t_di;
  wire [1:0] dsel;
  wire [31:0] id_value;
  wire bnd_ins;

  assign t_ms = pin_q[`BSTP_PIN_TMS];
  assign t_di = pin_q[`BSTP_PIN_TDI];
  assign dsel = dr_select(ir_q);
  assign bnd_ins = (dsel == SEL_BND);
  assign id_value = {ID_REVISION, ID_DEVICE, ID_VENDOR, 1'b1};

  // TAP controller
  // Five high mode samples from any state end in logic reset
  always @(posedge mclk)
  begin
    if (tap_rst)
      state_q <= ST_TLR;
    else if (tck_rise)
      state_q <= tap_next(state_q, t_ms);
  end

  always @(posedge mclk)
  begin
    if (tap_rst)
    begin
      ir_sr_q <= `BSTP_INS_IDCODE;
      ir_q <= `BSTP_INS_IDCODE;
    end
    else if (tck_rise)
    begin
      case (state_q)
        ST_TLR: ir_q <= `BSTP_INS_IDCODE;
        ST_CAP_IR: ir_sr_q <= `BSTP_IR_CAPTURE;
        ST_SH_IR: ir_sr_q <= {t_di, ir_sr_q[3:1]};
        // reserved codes fall back to bypass in decode
        ST_UPD_IR: ir_q <= ir_sr_q;
        default: ir_q <= ir_q;
      endcase
    end
  end

  // Data registers: capture, shift, update
  always @(posedge mclk)
  begin
    if (tap_rst)
    begin
      byp_q <= 1'b0;
      id_sr_q <= 32'h00000000;
      bnd_sr_q <= {`BSTP_BND_LEN{1'b0}};
      bnd_hold_q <= {`BSTP_BND_LEN{1'b0}};
    end
    else if (tck_rise)
    begin
      case (state_q)
        ST_CAP_DR:
        begin
          byp_q <= 1'b0;
          if (dsel == SEL_ID)
            id_sr_q <= id_value;
          if (bnd_ins)
            bnd_sr_q <= pin_capture;
        end
        ST_SH_DR:
        begin
          case (dsel)
            SEL_ID: id_sr_q <= {t_di, id_sr_q[31:1]};
            // 266-cell chain, cell 0 nearest the output
            SEL_BND: bnd_sr_q <= {t_di, bnd_sr_q[265:1]};
            default: byp_q <= t_di;
          endcase
        end
        ST_UPD_DR:
        begin
          if (bnd_ins)
            bnd_hold_q <= bnd_sr_q;
        end
        default:
        begin
          byp_q <= byp_q;
        end
      endcase
    end
  end

  // Test output on test clock fall
  reg tdo_d;
  always @*
  begin
    tdo_d = byp_q;
    if (state_q == ST_SH_IR)
      tdo_d = ir_sr_q[0];
    else if (dsel == SEL_ID)
      tdo_d = id_sr_q[0];
    else if (dsel == SEL_BND)
      tdo_d = bnd_sr_q[0];
  end

  always @(posedge mclk)
  begin
    if (tap_rst)
    begin
      tdo_q <= 1'b0;
      tdo_oe_q <= 1'b0;
    end
    else if (tck_fall)
    begin
      tdo_q <= tdo_d;
      tdo_oe_q <= (state_q == ST_SH_IR) | (state_q == ST_SH_DR);
    end
  end

  // Pin mode outputs; normal operation unless a test instruction holds
  wire [265:0] ctrl_mask;
  generate
    for (gi = 0; gi < `BSTP_BND_LEN; gi = gi + 1)
    begin : g_mask
      assign ctrl_mask[gi] = is_ctrl_cell(gi);
    end
  endgenerate

  always @(posedge mclk)
  begin
    if (tap_rst)
    begin
      test_drive_q <= 1'b0;
      test_highz_q <= 1'b0;
      bnd_oe_q <= {`BSTP_BND_LEN{1'b0}};
    end
    else
    begin
      test_drive_q <= (ir_q == `BSTP_INS_EXTEST) | (ir_q == `BSTP_INS_CLAMP);
      test_highz_q <= (ir_q == `BSTP_INS_HIGHZ);
      if (ir_q == `BSTP_INS_HIGHZ)
        bnd_oe_q <= {`BSTP_BND_LEN{1'b0}};
      else
        bnd_oe_q <= bnd_hold_q & ctrl_mask;
    end
  end

  // AXI4-Lite slave: address and data taken in either order
  reg aw_have_q;
  reg w_have_q;
  reg [3:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  wire do_write;
  integer bi;

  assign do_write = aw_have_q & w_have_q & ~s_axi_bvalid;

  always @(posedge mclk)
  begin
    if (rst)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `BSTP_RESP_OKAY;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 4'h0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      ctrl_q <= `BSTP_CTRL_RST;
    end
    else
    begin
      s_axi_awready <= ~aw_have_q & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready <= ~w_have_q & ~(s_axi_wvalid & s_axi_wready);
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_have_q <= 1'b1;
        // Addresses outside the window are held as an unmapped offset
        aw_addr_q <= (s_axi_awaddr[31:4] == 28'h0) ? s_axi_awaddr[3:0] : `BSTP_REG_NONE;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr_q == `BSTP_REG_CTRL)
        begin
          s_axi_bresp <= `BSTP_RESP_OKAY;
          for (bi = 0; bi < 4; bi = bi + 1)
            if (w_strb_q[bi])
              ctrl_q[bi*8 +: 8] <= w_data_q[bi*8 +: 8];
        end
        else if (aw_addr_q == `BSTP_REG_STATUS || aw_addr_q == `BSTP_REG_IDCODE)
          s_axi_bresp <= `BSTP_RESP_OKAY;
        else
          s_axi_bresp <= `BSTP_RESP_SLVERR;
      end
      else if (s_axi_bvalid & s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always @(posedge mclk)
  begin
    if (rst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `BSTP_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid & s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `BSTP_RESP_OKAY;
        if (s_axi_araddr[31:4] != 28'h0)
        begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `BSTP_RESP_SLVERR;
        end
        else
        begin
          case (s_axi_araddr[3:0])
            `BSTP_REG_CTRL: s_axi_rdata <= ctrl_q;
            `BSTP_REG_STATUS: s_axi_rdata <= {21'h0, test_highz_q,
              test_drive_q, tdo_oe_q, ir_q, state_q};
            `BSTP_REG_IDCODE: s_axi_rdata <= id_value;
            default:
            begin
              s_axi_rdata <= 32'h00000000;
              s_axi_rresp <= `BSTP_RESP_SLVERR;
            end
          endcase
        end
      end
      else if (s_axi_rvalid & s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ===== bstp_checker.sv
// Concurrent checks on the scan port outputs, all in the mclk domain.
// Bound to bstp_top from the testbench; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module bstp_checker (
  input wire logic mclk, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic tck, // Test clock pin
  input wire logic trst_n, // Test reset pin
  input wire logic tdo_oe_q, // Test output enable
  input wire logic [265:0] bnd_hold_q, // Held cells
  input wire logic [265:0] bnd_oe_q, // Cell enables
  input wire logic test_drive_q, // Held cells drive outputs
  input wire logic test_highz_q, // Outputs forced off
  input wire logic s_axi_arvalid, // Read address valid
  input wire logic s_axi_arready, // Read address ready
  input wire logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready // Write response ready
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (rst);
  oe_on_fall_a: assert property ($changed(tdo_oe_q) |-> !$past(tck, 2))
    else $error("tdo enable moved without a test clock fall");
  trst_clear_a: assert property ($fell(trst_n) |-> ##[1:8]
    (bnd_hold_q == '0 && !tdo_oe_q && !test_drive_q)) else $error("test reset left state");
  highz_off_a: assert property (test_highz_q && $past(test_highz_q) |-> bnd_oe_q == '0)
    else $error("driver enabled under high-z");
  mode_excl_a: assert property (test_drive_q |-> !test_highz_q)
    else $error("drive and high-z together");
  ctl_cell_a: assert property (!test_highz_q && !$past(test_highz_q) && $stable(bnd_hold_q)
    |-> bnd_oe_q[28] == bnd_hold_q[28] && bnd_oe_q[257] == bnd_hold_q[257]
    && !bnd_oe_q[27] && !bnd_oe_q[256]) else $error("control cell enable wrong");
  rd_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  rd_drop_a: assert property ($fell(s_axi_rvalid) |-> $past(s_axi_rready))
    else $error("rvalid dropped unaccepted");
  wr_drop_a: assert property ($fell(s_axi_bvalid) |-> $past(s_axi_bready))
    else $error("bvalid dropped unaccepted");
  ar_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("arready while read pending");
endmodule
`default_nettype wire

// ===== bstp_tester.sv
// Boundary-scan tester model driving the test pins at an 80 ns period.
// Assumes the device output settles within one test clock after a fall.
`timescale 1ns/1ps
`default_nettype none
module bstp_tester (
  output var logic tck, // Test clock, still between frames
  output var logic tms, // Mode select
  output var logic tdi, // Test data
  output var logic trst_n, // Test reset, active low
  input wire logic tdo_q, // Device test output
  input wire logic tdo_oe_q // Device output enable
);
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    trst_n = 1'b1;
  end
  // One test clock; o is the line just before the fall
  task step(input logic m, input logic di, output logic o);
    begin
      tms = m;
      tdi = di;
      #40 tck = 1'b1;
      #39 o = tdo_oe_q ? tdo_q : ~tdo_q;
      #1 tck = 1'b0;
    end
  endtask
  // Offset keeps test clock edges off mclk edges
  task run(input logic m, input int n);
    logic o;
    begin
      #3;
      repeat (n) step(m, 1'b1, o);
      tms = 1'b1;
    end
  endtask
  task scan(input logic ir, input int len, input logic [265:0] din, output logic [265:0] dout);
    int i;
    logic o;
    begin
      #3;
      dout = '0;
      step(1'b1, 1'b1, o);
      if (ir)
        step(1'b1, 1'b1, o);
      step(1'b0, 1'b1, o);
      step(1'b0, 1'b1, o);
      for (i = 0; i < len; i++)
      begin
        step(i == len - 1, din[i], o);
        dout[i] = o;
      end
      step(1'b1, 1'b1, o);
      step(1'b0, 1'b1, o);
      tms = 1'b1;
      tdi = 1'b1;
    end
  endtask
  task pulse_reset;
    begin
      #3 trst_n = 1'b0;
      #100 trst_n = 1'b1;
      #100;
    end
  endtask
endmodule
`default_nettype wire

// ===== testbench.sv
// Testbench: tester model on the scan pins, AXI4-Lite master tasks,
// checker bound to bstp_top below the module.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic tck, tms, tdi, trst_n, tdo_q, tdo_oe_q, test_drive_q, test_highz_q;
  logic [265:0] pin_capture = {133{2'b10}};
  logic [265:0] bnd_hold_q, bnd_oe_q, v;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [3:0] c;
  int errors = 0;
  int cmp_count = 0;
  localparam logic [31:0] ID = {4'h1, 16'h5a3c, 11'h0f1, 1'b1};
  localparam logic [23:0] CODES = 24'h1034f2;
  localparam logic [11:0] MODES = 12'b00_01_01_10_00_00;
  bstp_top DUT (.mclk, .rst, .tck, .tms, .tdi, .trst_n, .tdo_q, .tdo_oe_q, .pin_capture,
    .bnd_hold_q, .bnd_oe_q, .test_drive_q, .test_highz_q, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  bstp_tester tst (.tck, .tms, .tdi, .trst_n, .tdo_q, .tdo_oe_q);
  initial forever #5 mclk = ~mclk;
  task chk(input logic [265:0] got, input logic [265:0] exp);
    begin
      cmp_count++;
      if (got !== exp)
      begin
        errors++;
        $display("BAD %0t: got %0h expected %0h", $time, got, exp);
      end
    end
  endtask
  task axi_wr(input logic [31:0] a, input logic [31:0] wd);
    begin
      @(posedge mclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= wd;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      r = 2'h3;
      while (r === 2'h3)
      begin
        @(posedge mclk);
        if (s_axi_awready)
          s_axi_awvalid <= 1'b0;
        if (s_axi_wready)
          s_axi_wvalid <= 1'b0;
        if (s_axi_bvalid)
        begin
          r = s_axi_bresp;
          s_axi_bready <= 1'b0;
        end
      end
    end
  endtask
  task axi_rd(input logic [31:0] a);
    begin
      @(posedge mclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      r = 2'h3;
      while (r === 2'h3)
      begin
        @(posedge mclk);
        if (s_axi_arready)
          s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid)
        begin
          r = s_axi_rresp;
          d = s_axi_rdata;
          s_axi_rready <= 1'b0;
        end
      end
    end
  endtask
  task complete_run;
    begin
      $display("errors %0d compares %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  initial
  begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    axi_rd(32'h4);
    chk({r, d}, {2'h0, 32'h20});
    axi_rd(32'h8);
    chk(d, ID);
    axi_wr(32'h8, 32'h0);
    chk(r, 2'h0);
    axi_rd(32'h10);
    chk({r, d}, {2'h2, 32'h0});
    axi_wr(32'h10, 32'h1);
    chk(r, 2'h2);
    tst.run(1'b0, 1);
    tst.scan(1'b0, 32, '0, v);
    chk(v[31:0], ID);
    for (int k = 0; k < 6; k++)
    begin
      c = CODES[4 * (5 - k) +: 4];
      tst.scan(1'b1, 4, {262'h0, c}, v);
      chk(v[3:0], 4'h1);
      axi_rd(32'h4);
      chk(d[10:0], {MODES[2 * (5 - k) +: 2], 1'b0, c, 4'h1});
      if (c == 4'h1)
      begin
        tst.scan(1'b0, 266, '1, v);
        chk(v, pin_capture);
      end
      else if (c == 4'h0)
      begin
        chk(bnd_hold_q, '1);
        chk(bnd_oe_q[29:27], 3'b010);
      end
      else if (c != 4'h2)
      begin
        tst.scan(1'b0, 8, 8'hb5, v);
        chk(v[7:0], 8'h6a);
      end
    end
    tst.pulse_reset;
    axi_rd(32'h4);
    chk(d, 32'h20);
    chk(bnd_hold_q, '0);
    tst.run(1'b0, 1);
    tst.scan(1'b1, 4, 4'hf, v);
    tst.run(1'b1, 6);
    axi_rd(32'h4);
    chk(d[7:0], 8'h20);
    tst.run(1'b0, 1);
    axi_wr(32'h0, 32'h1);
    axi_rd(32'h0);
    chk({r, d}, {2'h0, 32'h1});
    axi_rd(32'h4);
    chk(d[3:0], 4'h0);
    axi_wr(32'h0, 32'h0);
    complete_run;
  end
  initial
  begin
    #200us;
    errors++;
    complete_run;
  end
endmodule
bind bstp_top bstp_checker u_chk (.mclk, .rst, .tck, .trst_n, .tdo_oe_q, .bnd_hold_q,
  .bnd_oe_q, .test_drive_q, .test_highz_q, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_bvalid, .s_axi_bready);
`default_nettype wire
